//--- jlx_pkg.sv
// package: register map, field layout, reset values and carrier structs for the lane receiver config block
package jlx_pkg;

  // ==========================================================================
  // register offsets (byte offsets on the register port)
  localparam logic [11:0] JLX_OFS_LINK_CTRL = 12'h300;  // link enable in bit 0
  localparam logic [11:0] JLX_OFS_DYN_LAT = 12'h302;    // link0_dynamic_latency
  localparam logic [11:0] JLX_OFS_FIX_DLY = 12'h304;    // link0_multiframe_fixed_delay
  localparam logic [11:0] JLX_OFS_VAR_DLY = 12'h306;    // link0_multiframe_variable_delay
  localparam logic [11:0] JLX_OFS_XBAR_01 = 12'h308;    // lane_crossbar_0_1
  localparam logic [11:0] JLX_OFS_XBAR_23 = 12'h309;    // lane_crossbar_2_3

  // ==========================================================================
  // field layout
  localparam int JLX_LINK_EN_BIT = 0;   // link enable position
  localparam int JLX_DLY_W = 5;         // width of latency and delay fields
  localparam int JLX_SRC_W = 3;         // width of one source select field
  localparam int JLX_SRC_LO_POS = 0;    // even logical lane source field
  localparam int JLX_SRC_HI_POS = 3;    // odd logical lane source field
  localparam int JLX_PHYS_N = 8;        // physical serial input pairs
  localparam int JLX_LOG_N = 4;         // logical lanes served here
  localparam int JLX_GDLY_DEPTH = 32;   // taps of the fixed delay line

  // ==========================================================================
  // reset values
  localparam logic JLX_RST_LINK_EN = 1'h0;
  localparam logic [4:0] JLX_RST_DYN_LAT = 5'h00;
  localparam logic [4:0] JLX_RST_FIX_DLY = 5'h00;
  localparam logic [4:0] JLX_RST_VAR_DLY = 5'h1f;
  localparam logic [2:0] JLX_RST_SRC0 = 3'h0;
  localparam logic [2:0] JLX_RST_SRC1 = 3'h1;
  localparam logic [2:0] JLX_RST_SRC2 = 3'h2;
  localparam logic [2:0] JLX_RST_SRC3 = 3'h3;
  localparam logic [4:0] JLX_CNT_MAX = 5'h1f;  // saturation of five-bit counts

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic wr;            // one-cycle write strobe
    logic rd;            // one-cycle read strobe
    logic [11:0] addr;   // register offset
    logic [7:0] wdata;   // write data
  } jlx_reg_req_s;

  typedef struct packed {
    logic valid;         // read data valid, one cycle
    logic [7:0] rdata;   // read data
  } jlx_reg_rsp_s;

  // latency measurement states
  typedef enum logic [0:0] {
    JLX_MEAS_IDLE,
    JLX_MEAS_RUN
  } jlx_meas_e;

endpackage

//--- jlx_rx_config.sv
// module: lane crossbar, multiframe delay settings and link latency measurement for the lane receiver
`timescale 1ns/100ps

module jlx_rx_config #(
  parameter int LANE_W = 16  // bits per lane word
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire jlx_pkg::jlx_reg_req_s req_in,
  output jlx_pkg::jlx_reg_rsp_s rsp_out,
  input wire logic [jlx_pkg::JLX_PHYS_N-1:0][LANE_W-1:0] serial_input_pair_in,
  input wire logic lmfc_global_in,
  input wire logic lmfc_local_in,
  output logic link_enable_out,
  output logic lmfc_delayed_out,
  output logic buffer_read_out,
  output logic [jlx_pkg::JLX_DLY_W-1:0] measured_link_latency_out,
  output logic [jlx_pkg::JLX_LOG_N-1:0][LANE_W-1:0] logic_lane_out
);
  import jlx_pkg::*;

  // ==========================================================================
  // state record
  typedef struct packed {
    logic link_en;                                   // receiver running
    logic [JLX_DLY_W-1:0] fixed_dly;                 // multiframe_fixed_delay
    logic [JLX_DLY_W-1:0] var_dly;                   // multiframe_variable_delay
    logic [JLX_LOG_N-1:0][JLX_SRC_W-1:0] src;        // per-lane source select
    logic [JLX_DLY_W-1:0] latency;                   // measured_link_latency
    logic [JLX_DLY_W-1:0] meas_cnt;                  // running latency count
    jlx_meas_e meas;                                 // measurement phase
    logic [JLX_GDLY_DEPTH-1:0] gline;                // global pulse history
    logic [JLX_DLY_W-1:0] mf_pos;                    // position in multiframe
    logic pos_valid;                                 // a delayed pulse was seen
    logic delayed;                                   // delayed global pulse out
    logic rd_strobe;                                 // buffer read-out strobe
    jlx_reg_rsp_s rsp;                               // register answer
    logic [JLX_LOG_N-1:0][LANE_W-1:0] lanes;         // routed lane data
  } jlx_state_s;

  jlx_state_s st_q;  // registered state
  jlx_state_s st_d;  // next state

  // ==========================================================================
  // helpers
  // pick one physical input by binary index; plain mux so any number
  // of lanes may read the same input at once
  function automatic logic [LANE_W-1:0] jlx_pick(
    input logic [JLX_PHYS_N-1:0][LANE_W-1:0] phys,
    input logic [JLX_SRC_W-1:0] sel
  );
    jlx_pick = phys[sel];
  endfunction

  // five-bit count that sticks at its top value instead of wrapping
  function automatic logic [JLX_DLY_W-1:0] jlx_sat_inc(input logic [JLX_DLY_W-1:0] v);
    jlx_sat_inc = (v == JLX_CNT_MAX) ? v : JLX_DLY_W'(v + 5'h01);
  endfunction

  // read decode; unmapped offsets and reserved bits give zero
  function automatic logic [7:0] jlx_read(input jlx_state_s s, input logic [11:0] a);
    case (a)
      JLX_OFS_LINK_CTRL: jlx_read = {7'h00, s.link_en};
      JLX_OFS_DYN_LAT: jlx_read = {3'h0, s.latency};
      JLX_OFS_FIX_DLY: jlx_read = {3'h0, s.fixed_dly};
      JLX_OFS_VAR_DLY: jlx_read = {3'h0, s.var_dly};
      JLX_OFS_XBAR_01: jlx_read = {2'h0, s.src[1], s.src[0]};
      JLX_OFS_XBAR_23: jlx_read = {2'h0, s.src[3], s.src[2]};
      default: jlx_read = 8'h00;
    endcase
  endfunction

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic glob_dly;                   // global pulse after the fixed delay
    logic [JLX_DLY_W-1:0] tap;        // delay line tap index
    glob_dly = 1'b0;
    tap = '0;
    st_d = st_q;

    // register writes: only defined field bits are stored
    if (req_in.wr) begin
      case (req_in.addr)
        JLX_OFS_LINK_CTRL: st_d.link_en = req_in.wdata[JLX_LINK_EN_BIT];
        JLX_OFS_FIX_DLY: st_d.fixed_dly = req_in.wdata[JLX_DLY_W-1:0];
        JLX_OFS_VAR_DLY: st_d.var_dly = req_in.wdata[JLX_DLY_W-1:0];
        JLX_OFS_XBAR_01: begin
          st_d.src[0] = req_in.wdata[JLX_SRC_LO_POS +: JLX_SRC_W];
          st_d.src[1] = req_in.wdata[JLX_SRC_HI_POS +: JLX_SRC_W];
        end
        JLX_OFS_XBAR_23: begin
          st_d.src[2] = req_in.wdata[JLX_SRC_LO_POS +: JLX_SRC_W];
          st_d.src[3] = req_in.wdata[JLX_SRC_HI_POS +: JLX_SRC_W];
        end
        default: begin
          // unmapped or read-only offset: write dropped
        end
      endcase
    end

    // read answer one cycle after the strobe, from pre-write contents
    st_d.rsp.valid = req_in.rd;
    st_d.rsp.rdata = req_in.rd ? jlx_read(st_q, req_in.addr) : 8'h00;

    // fixed delay: tap the global pulse history; zero means no delay
    st_d.gline = {st_q.gline[JLX_GDLY_DEPTH-2:0], lmfc_global_in};
    if (st_q.fixed_dly == '0) begin
      glob_dly = lmfc_global_in;
    end else begin
      tap = JLX_DLY_W'(st_q.fixed_dly - 5'h01);
      glob_dly = st_q.gline[tap];
    end

    // the delayed pulse and everything it times stop while the link is down
    if (!st_q.link_en) begin
      glob_dly = 1'b0;
    end
    st_d.delayed = glob_dly;

    // position inside the multiframe, restarted by each delayed pulse
    if (!st_q.link_en) begin
      st_d.pos_valid = 1'b0;
      st_d.mf_pos = '0;
    end else if (glob_dly) begin
      st_d.pos_valid = 1'b1;
      st_d.mf_pos = '0;
    end else begin
      st_d.mf_pos = jlx_sat_inc(st_q.mf_pos);
    end
    // read-out point; with the reset value 0x1f it falls at the count's
    // top and pulses once as the count arrives, not while it sticks there; software must lower it first
    st_d.rd_strobe = st_d.pos_valid && (st_d.mf_pos == st_q.var_dly)
                     && (st_d.mf_pos != st_q.mf_pos || glob_dly);

    // latency from the delayed global pulse to the local pulse
    case (st_q.meas)
      JLX_MEAS_IDLE: begin
        if (st_q.link_en && glob_dly) begin
          if (lmfc_local_in) begin
            st_d.latency = '0;
          end else begin
            st_d.meas_cnt = 5'h01;
            st_d.meas = JLX_MEAS_RUN;
          end
        end
      end
      JLX_MEAS_RUN: begin
        if (!st_q.link_en) begin
          st_d.meas = JLX_MEAS_IDLE;
        end else if (lmfc_local_in) begin
          st_d.latency = st_q.meas_cnt;
          st_d.meas = JLX_MEAS_IDLE;
        end else begin
          st_d.meas_cnt = jlx_sat_inc(st_q.meas_cnt);
        end
      end
      default: begin
        st_d.meas = JLX_MEAS_IDLE;
      end
    endcase

    // crossbar, registered so lane outputs leave flip-flops
    for (int i = 0; i < JLX_LOG_N; i++) begin
      st_d.lanes[i] = jlx_pick(serial_input_pair_in, st_q.src[i]);
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= '0;
      st_q.link_en <= JLX_RST_LINK_EN;
      st_q.latency <= JLX_RST_DYN_LAT;
      st_q.fixed_dly <= JLX_RST_FIX_DLY;
      st_q.var_dly <= JLX_RST_VAR_DLY;
      st_q.src[0] <= JLX_RST_SRC0;
      st_q.src[1] <= JLX_RST_SRC1;
      st_q.src[2] <= JLX_RST_SRC2;
      st_q.src[3] <= JLX_RST_SRC3;
      st_q.meas <= JLX_MEAS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs, all straight from the state record
  assign rsp_out = st_q.rsp;
  assign link_enable_out = st_q.link_en;
  assign lmfc_delayed_out = st_q.delayed;
  assign buffer_read_out = st_q.rd_strobe;
  assign measured_link_latency_out = st_q.latency;
  assign logic_lane_out = st_q.lanes;

endmodule

//--- jlx_rx_config_properties.sv
// checker: port timing properties of the lane receiver config block
`timescale 1ns/100ps
module jlx_rx_config_props
  import jlx_pkg::*;
#(parameter int LANE_W = 16) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire jlx_pkg::jlx_reg_req_s req_in,
  input wire jlx_pkg::jlx_reg_rsp_s rsp_out,
  input wire logic [jlx_pkg::JLX_PHYS_N-1:0][LANE_W-1:0] serial_input_pair_in,
  input wire logic lmfc_global_in,
  input wire logic lmfc_local_in,
  input wire logic link_enable_out,
  input wire logic lmfc_delayed_out,
  input wire logic buffer_read_out,
  input wire logic [jlx_pkg::JLX_DLY_W-1:0] measured_link_latency_out,
  input wire logic [jlx_pkg::JLX_LOG_N-1:0][LANE_W-1:0] logic_lane_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // shadow settings, tracked from writes so routes can be predicted
  logic [3:0][2:0] src_q;
  logic [4:0] fix_q;
  logic [4:0] var_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      src_q <= {3'h3, 3'h2, 3'h1, 3'h0};
      fix_q <= 5'h00;
      var_q <= 5'h1f;
    end else if (req_in.wr) begin
      if (req_in.addr == 12'h308) src_q[1:0] <= {req_in.wdata[5:3], req_in.wdata[2:0]};
      if (req_in.addr == 12'h309) src_q[3:2] <= {req_in.wdata[5:3], req_in.wdata[2:0]};
      if (req_in.addr == 12'h304) fix_q <= req_in.wdata[4:0];
      if (req_in.addr == 12'h306) var_q <= req_in.wdata[4:0];
    end
  end
  // ==========================================
  // properties
  property p_rd_ans; req_in.rd |=> rsp_out.valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  property p_no_spur; !req_in.rd |=> !rsp_out.valid && rsp_out.rdata == 8'h00; endproperty
  a_no_spur: assert property (p_no_spur) else $error("spurious answer");
  property p_resv; rsp_out.valid |-> rsp_out.rdata[7:6] == 2'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  // first edge after reset still sees the lanes zeroed by reset, so skip it
  property p_lane0; !$past(rst_in) |-> logic_lane_out[0] == $past(serial_input_pair_in[src_q[0]]); endproperty
  a_lane0: assert property (p_lane0) else $error("lane 0 route");
  property p_lane3; !$past(rst_in) |-> logic_lane_out[3] == $past(serial_input_pair_in[src_q[3]]); endproperty
  a_lane3: assert property (p_lane3) else $error("lane 3 route");
  property p_fix; lmfc_global_in && link_enable_out && fix_q == 5'h02 |=> ##2 lmfc_delayed_out; endproperty
  a_fix: assert property (p_fix) else $error("fixed delay");
  property p_var; lmfc_delayed_out && link_enable_out && var_q == 5'h03 |-> ##3 buffer_read_out; endproperty
  a_var: assert property (p_var) else $error("read-out point");
  property p_lat; lmfc_delayed_out && link_enable_out ##1 lmfc_local_in |=> measured_link_latency_out == 5'h02;
  endproperty
  a_lat: assert property (p_lat) else $error("latency value");
  property p_off; !link_enable_out |=> !lmfc_delayed_out && !buffer_read_out; endproperty
  a_off: assert property (p_off) else $error("pulse while disabled");
  c_read: cover property (req_in.rd ##1 rsp_out.valid);
  c_lat: cover property (lmfc_local_in && link_enable_out);
  c_buf: cover property (buffer_read_out);
endmodule

//--- jlx_xmit_model.sv
// partner: transmitter model feeding eight lanes with tagged words
`timescale 1ns/100ps
module jlx_xmit_model #(parameter int LANE_W = 16) (
  input wire logic clk_in,
  output logic [7:0][LANE_W-1:0] lanes_out
);
  logic [11:0] cnt_q = 12'h000;  // word count, new word each cycle
  // advance off the sampling edge
  always @(negedge clk_in) cnt_q <= cnt_q + 12'h001;
  // lane index in top nibble so a wrong source is always visible
  always_comb for (int i = 0; i < 8; i++) lanes_out[i] = LANE_W'({4'(i), cnt_q});
endmodule

//--- tb_jlx_rx_config.sv
// testbench: registers, crossbar and multiframe timing of the lane receiver config block
`timescale 1ns/100ps
module tb_jlx_rx_config;
  import jlx_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  jlx_reg_req_s req = '0;
  jlx_reg_rsp_s rsp;
  logic [7:0][15:0] ser;
  logic glob = 1'b0;
  logic loc = 1'b0;
  logic en, dly, brd;
  logic [4:0] lat;
  logic [3:0][15:0] lanes;
  logic [11:0] ra [7] = '{12'h300, 12'h302, 12'h304, 12'h306, 12'h308, 12'h309, 12'h301};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h1f, 8'h08, 8'h1a, 8'h00};
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  initial forever #50 clk_in = ~clk_in;
  jlx_xmit_model #(.LANE_W(16)) xmit_u (.clk_in(clk_in), .lanes_out(ser));
  jlx_rx_config #(.LANE_W(16)) dut_u (.clk_in(clk_in), .rst_in(rst_in), .req_in(req), .rsp_out(rsp),
    .serial_input_pair_in(ser), .lmfc_global_in(glob), .lmfc_local_in(loc), .link_enable_out(en),
    .lmfc_delayed_out(dly), .buffer_read_out(brd), .measured_link_latency_out(lat), .logic_lane_out(lanes));
  // ==========================================
  // helpers
  task automatic final_report();
    $display("compares %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_in) req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_in) req.wr = 1'b0;
  endtask
  // answer stands one cycle after the read edge
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk_in) req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_in) req.rd = 1'b0;
    chk(rsp.valid === 1'b1 && rsp.rdata === e, "read value");
  endtask
  task automatic lane_chk(input logic [3:0][2:0] s);
    @(posedge clk_in);
    #1;
    for (int l = 0; l < 4; l++) chk(lanes[l] === ser[s[l]], "lane route");
  endtask
  // hang guard, run needs about a hundred cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 2000) begin
      err_total++;
      final_report();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 7; i++) rd_chk(ra[i], rv[i]);
    lane_chk({3'h3, 3'h2, 3'h1, 3'h0});
    for (int k = 0; k < 8; k++) begin
      wr(12'h308, {2'h3, 3'(7 - k), 3'(k)});
      rd_chk(12'h308, {2'h0, 3'(7 - k), 3'(k)});
      lane_chk({3'h3, 3'h2, 3'(7 - k), 3'(k)});
    end
    wr(12'h309, 8'hed);
    lane_chk({3'h5, 3'h5, 3'h0, 3'h7});
    wr(12'h302, 8'hff);
    rd_chk(12'h302, 8'h00);
    wr(12'h304, 8'hff);
    rd_chk(12'h304, 8'h1f);
    wr(12'h304, 8'h02);
    wr(12'h306, 8'h03);
    rd_chk(12'h306, 8'h03);
    wr(12'h300, 8'hff);
    rd_chk(12'h300, 8'h01);
    chk(en === 1'b1, "link enable pin");
    // global pulse, fixed 2: delayed pulse sampled three edges later, local one after that
    @(negedge clk_in) glob = 1'b1;
    @(negedge clk_in) glob = 1'b0;
    @(negedge clk_in) chk(dly === 1'b0, "early delayed pulse");
    @(negedge clk_in) chk(dly === 1'b1, "delayed pulse");
    @(negedge clk_in) chk(dly === 1'b0, "delayed pulse too long");
    loc = 1'b1;
    @(negedge clk_in) loc = 1'b0;
    chk(brd === 1'b0, "early read-out");
    chk(lat === 5'h02, "latency");
    @(negedge clk_in) chk(brd === 1'b1, "read-out pulse");
    @(negedge clk_in) chk(brd === 1'b0, "read-out pulse too long");
    // link off: pulses are ignored
    wr(12'h300, 8'h00);
    chk(en === 1'b0, "link enable pin off");
    @(negedge clk_in) glob = 1'b1;
    @(negedge clk_in) glob = 1'b0;
    repeat (6) @(negedge clk_in) chk(dly === 1'b0 && brd === 1'b0, "pulse while off");
    final_report();
  end
endmodule
bind jlx_rx_config jlx_rx_config_props #(.LANE_W(LANE_W)) props_u (.clk_in(clk_in), .rst_in(rst_in),
  .req_in(req_in), .rsp_out(rsp_out), .serial_input_pair_in(serial_input_pair_in),
  .lmfc_global_in(lmfc_global_in), .lmfc_local_in(lmfc_local_in), .link_enable_out(link_enable_out),
  .lmfc_delayed_out(lmfc_delayed_out), .buffer_read_out(buffer_read_out),
  .measured_link_latency_out(measured_link_latency_out), .logic_lane_out(logic_lane_out));
